// ---- fpc_debounce.sv ----
`timescale 1ns/100ps
module fpc_debounce #(
  parameter int CYCLES = 500000
) (
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic level_i,
  output logic      pulse_o
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_r;
  logic          stable_r;

  // level must hold unchanged for the whole settle time before it counts
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_r  <= '0;
      stable_r <= 1'b0;
    end else if (level_i == stable_r) begin
      count_r <= '0;
    end else if (count_r == CW'(CYCLES - 1)) begin
      count_r  <= '0;
      stable_r <= level_i;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= (count_r == CW'(CYCLES - 1)) && level_i && !stable_r;
    end
  end

  property p_single_pulse;
    @(posedge clock_i) disable iff (reset_i)
    pulse_o |=> !pulse_o;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("action pulse longer than one cycle");
endmodule

// ---- fpc_map.svh ----
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH

// clock rates and derived tick spacing
`define FPC_CLK_MHZ          100
`define FPC_CPU_MHZ          2
`define FPC_TICK_CYCLES      (`FPC_CLK_MHZ / `FPC_CPU_MHZ)

// contact bounce settle time
`define FPC_DEBOUNCE_US      5000
`define FPC_DEBOUNCE_CYCLES  (`FPC_DEBOUNCE_US * `FPC_CLK_MHZ)

// longest instruction in machine cycles
`define FPC_MAX_MCYCLES      5

// register byte offsets
`define FPC_REG_CTRL         8'h00
`define FPC_REG_STAT         8'h04
`define FPC_REG_ADDR         8'h08
`define FPC_REG_DATA         8'h0C

// control register fields
`define FPC_CTRL_LOCK_BIT    0
`define FPC_CTRL_HALT_BIT    1
`define FPC_CTRL_RESET       2'h0

// status register fields
`define FPC_STAT_RUN_BIT     0
`define FPC_STAT_STEP_BIT    1
`define FPC_STAT_LOCK_BIT    2
`define FPC_STAT_BUSY_BIT    3

// momentary control indices
`define FPC_ACT_STEP         0
`define FPC_ACT_EXAM         1
`define FPC_ACT_EXNEXT       2
`define FPC_ACT_DEP          3
`define FPC_ACT_DEPNEXT      4
`define FPC_ACT_RESET        5
`define FPC_ACT_CLEAR        6
`define FPC_ACT_COUNT        7

`endif

// ---- fpc_mem_model.sv ----
`timescale 1ns/100ps
module fpc_mem_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  input  wire logic        mem_we_i,
  input  wire logic        mem_re_i,
  output logic      [7:0]  mem_rdata_o
);
  logic [7:0] mem [256];
  logic [7:0] stale_r = 8'h00;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
  end
  // small memory: upper address bits are not decoded
  always @(posedge clock_i) begin
    if (mem_we_i) begin
      mem[mem_addr_i[7:0]] <= mem_wdata_i;
    end
    // stale data flips every cycle so a sample outside the strobe is caught
    stale_r <= ~stale_r;
  end
  // data stand while the strobe is high; the panel takes them at the next edge
  assign mem_rdata_o = mem_re_i ? mem[mem_addr_i[7:0]] : stale_r;
endmodule

// ---- fpc_panel.sv ----
// Summary of operation
// - processor steps come from a 2 MHz enable derived from the system clock.
// - external interrupt reaches the processor only while interrupts are enabled.
// - 256 input and 256 output port addresses decoded from the low address byte.
// - stop position halts execution, run position lets it proceed unless the control register halt bit is set.
// - single step runs one instruction, at most five machine cycles, then stops.
// - examine reads the switch address and shows the byte on data lamps.
// - examine next advances the panel address and shows the new byte.
// - deposit writes the data switch byte into the current panel address.
// - deposit next advances the panel address and writes the switch byte there.
// - data switches are sampled at the moment of each deposit actuation.
// - reset loads the program counter with zero on all sixteen bits.
// - clear sends a clear command to attached peripheral equipment.
// - protect blocks every memory write, unprotect permits writes unless the control register lock bit is set.
// - data switches are bits 7-0, address switches 15-0, up means one.
// - address lamps show the address being examined or loaded.
// - data lamps show the byte held at the current address.
// - lamps for interrupt enable, protect, wait and hold acknowledge.
// - status lamps for memory read, port read, port write and opcode fetch.
// - a status lamp marks write or output cycles against read or input.
// - status lamps for halt acknowledge, stack access and interrupt acknowledge.
// - lamps are meaningful when stopped; while running they follow the bus.
`timescale 1ns/100ps
`include "fpc_map.svh"
module fpc_panel
  import fpc_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = `FPC_DEBOUNCE_CYCLES,
  parameter int TICK_CYCLES     = `FPC_TICK_CYCLES,
  parameter int MAX_MCYCLES     = `FPC_MAX_MCYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        sw_run_i,
  input  wire logic        sw_protect_i,
  input  wire logic        sw_step_i,
  input  wire logic        sw_examine_i,
  input  wire logic        sw_examine_next_i,
  input  wire logic        sw_deposit_i,
  input  wire logic        sw_deposit_next_i,
  input  wire logic        sw_reset_i,
  input  wire logic        sw_clear_i,
  input  wire logic [15:0] sw_addr_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0]  cpu_dout_i,
  input  wire logic        cpu_mem_we_i,
  input  wire logic        cpu_mem_re_i,
  input  wire logic        cpu_cycle_start_i,
  input  wire logic        cpu_instr_end_i,
  input  wire logic        cpu_wait_i,
  input  wire logic        ext_irq_i,
  input  wire logic        irq_enable_flag_i,
  input  wire logic        bus_hold_granted_flag_i,
  input  wire logic        memory_read_cycle_flag_i,
  input  wire logic        port_read_cycle_flag_i,
  input  wire logic        port_write_cycle_flag_i,
  input  wire logic        opcode_fetch_flag_i,
  input  wire logic        write_direction_flag_i,
  input  wire logic        stop_instruction_ack_flag_i,
  input  wire logic        stack_cycle_flag_i,
  input  wire logic        irq_ack_flag_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             cpu_tick_o,
  output logic             cpu_irq_o,
  output logic             pc_clear_o,
  output logic             peripheral_wipe_o,
  output logic      [15:0] mem_addr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             mem_we_o,
  output logic             mem_re_o,
  output logic      [7:0]  port_addr_o,
  output logic             port_rd_o,
  output logic             port_wr_o,
  output logic      [15:0] lamp_addr_o,
  output logic      [7:0]  lamp_data_o,
  output logic             lamp_irq_enable_o,
  output logic             lamp_write_lock_o,
  output logic             lamp_wait_o,
  output logic             lamp_hold_o,
  output logic             lamp_mem_read_o,
  output logic             lamp_port_read_o,
  output logic             lamp_port_write_o,
  output logic             lamp_opcode_fetch_o,
  output logic             lamp_write_dir_o,
  output logic             lamp_stop_ack_o,
  output logic             lamp_stack_o,
  output logic             lamp_irq_ack_o
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int MW = $clog2(MAX_MCYCLES + 1);

  logic [`FPC_ACT_COUNT-1:0] act;
  logic [`FPC_ACT_COUNT-1:0] act_level;
  logic [1:0]                ctrl_r;
  logic [TW-1:0]             tick_cnt_r;
  logic                      step_r;
  logic [MW-1:0]             mcyc_r;
  logic                      running;
  logic                      can_act;
  logic                      write_lock;
  logic                      tick_now;
  fpc_state_type             state_r;
  logic [15:0]               panel_addr_r;
  logic [7:0]                panel_data_r;
  logic [7:0]                dep_byte_r;

  function automatic logic [15:0] next_addr(input logic [15:0] a);
    next_addr = a + 16'h0001;
  endfunction

  assign act_level = {sw_clear_i, sw_reset_i, sw_deposit_next_i, sw_deposit_i,
                      sw_examine_next_i, sw_examine_i, sw_step_i};

  genvar gi;
  generate
    for (gi = 0; gi < `FPC_ACT_COUNT; gi++) begin : g_db
      fpc_debounce #(
        .CYCLES (DEBOUNCE_CYCLES)
      ) u_db (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .level_i (act_level[gi]),
        .pulse_o (act[gi])
      );
    end
  endgenerate

  assign running    = (sw_run_i && !ctrl_r[`FPC_CTRL_HALT_BIT]) || step_r;
  assign can_act    = !running && (state_r == FPC_IDLE);
  assign write_lock = sw_protect_i || ctrl_r[`FPC_CTRL_LOCK_BIT];
  assign tick_now   = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  // register port
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_r <= `FPC_CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == `FPC_REG_CTRL) begin
      ctrl_r <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `FPC_REG_CTRL: reg_rdata_o <= {30'h0000_0000, ctrl_r};
        `FPC_REG_STAT: reg_rdata_o <= {28'h0000_000, state_r != FPC_IDLE,
                                       write_lock, step_r, running};
        `FPC_REG_ADDR: reg_rdata_o <= {16'h0000, panel_addr_r};
        `FPC_REG_DATA: reg_rdata_o <= {24'h00_0000, panel_data_r};
        default:       reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // processor clock enable, free-running divider so the tick rate never drifts
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick_cnt_r <= '0;
      cpu_tick_o <= 1'b0;
    end else begin
      tick_cnt_r <= tick_now ? '0 : tick_cnt_r + 1'b1;
      cpu_tick_o <= tick_now && running;
    end
  end

  // single step: run until instruction end or the machine cycle cap
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      step_r <= 1'b0;
      mcyc_r <= '0;
    end else if (!step_r) begin
      mcyc_r <= '0;
      if (act[`FPC_ACT_STEP] && can_act) begin
        step_r <= 1'b1;
      end
    end else if (cpu_instr_end_i || (mcyc_r == MW'(MAX_MCYCLES))) begin
      step_r <= 1'b0;
    end else if (cpu_cycle_start_i) begin
      mcyc_r <= mcyc_r + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cpu_irq_o <= 1'b0;
    end else begin
      cpu_irq_o <= ext_irq_i && irq_enable_flag_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pc_clear_o        <= 1'b0;
      peripheral_wipe_o <= 1'b0;
    end else begin
      pc_clear_o        <= act[`FPC_ACT_RESET] && can_act;
      peripheral_wipe_o <= act[`FPC_ACT_CLEAR] && can_act;
    end
  end

  // panel sequencer; bytes are read back after a write so lamps show memory truth
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r      <= FPC_IDLE;
      panel_addr_r <= 16'h0000;
      panel_data_r <= 8'h00;
      dep_byte_r   <= 8'h00;
    end else begin
      unique case (state_r)
        FPC_IDLE: begin
          if (can_act) begin
            if (act[`FPC_ACT_EXAM]) begin
              panel_addr_r <= sw_addr_i;
              state_r      <= FPC_READ;
            end else if (act[`FPC_ACT_EXNEXT]) begin
              panel_addr_r <= next_addr(panel_addr_r);
              state_r      <= FPC_READ;
            end else if (act[`FPC_ACT_DEP]) begin
              dep_byte_r <= sw_addr_i[7:0];
              state_r    <= FPC_WRITE;
            end else if (act[`FPC_ACT_DEPNEXT]) begin
              panel_addr_r <= next_addr(panel_addr_r);
              dep_byte_r   <= sw_addr_i[7:0];
              state_r      <= FPC_WRITE;
            end
          end
        end
        FPC_WRITE: state_r <= FPC_READ;
        FPC_READ:  state_r <= FPC_LATCH;
        FPC_LATCH: begin
          panel_data_r <= mem_rdata_i;
          state_r      <= FPC_IDLE;
        end
      endcase
    end
  end

  // memory port: panel owns it while stopped, processor while running
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mem_addr_o  <= 16'h0000;
      mem_wdata_o <= 8'h00;
      mem_we_o    <= 1'b0;
      mem_re_o    <= 1'b0;
    end else if (running) begin
      mem_addr_o  <= cpu_addr_i;
      mem_wdata_o <= cpu_dout_i;
      mem_we_o    <= cpu_mem_we_i && !write_lock;
      mem_re_o    <= cpu_mem_re_i;
    end else begin
      mem_addr_o  <= panel_addr_r;
      mem_wdata_o <= dep_byte_r;
      mem_we_o    <= (state_r == FPC_WRITE) && !write_lock;
      mem_re_o    <= (state_r == FPC_READ);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      port_addr_o <= 8'h00;
      port_rd_o   <= 1'b0;
      port_wr_o   <= 1'b0;
    end else begin
      port_addr_o <= cpu_addr_i[7:0];
      port_rd_o   <= running && port_read_cycle_flag_i;
      port_wr_o   <= running && port_write_cycle_flag_i;
    end
  end

  // lamps track the processor bus while running; no meaning is promised then
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      lamp_addr_o <= 16'h0000;
      lamp_data_o <= 8'h00;
    end else if (running) begin
      lamp_addr_o <= cpu_addr_i;
      lamp_data_o <= cpu_dout_i;
    end else begin
      lamp_addr_o <= panel_addr_r;
      lamp_data_o <= panel_data_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      lamp_irq_enable_o   <= 1'b0;
      lamp_write_lock_o   <= 1'b0;
      lamp_wait_o         <= 1'b0;
      lamp_hold_o         <= 1'b0;
      lamp_mem_read_o     <= 1'b0;
      lamp_port_read_o    <= 1'b0;
      lamp_port_write_o   <= 1'b0;
      lamp_opcode_fetch_o <= 1'b0;
      lamp_write_dir_o    <= 1'b0;
      lamp_stop_ack_o     <= 1'b0;
      lamp_stack_o        <= 1'b0;
      lamp_irq_ack_o      <= 1'b0;
    end else begin
      lamp_irq_enable_o   <= irq_enable_flag_i;
      lamp_write_lock_o   <= write_lock;
      lamp_wait_o         <= cpu_wait_i || !running;
      lamp_hold_o         <= bus_hold_granted_flag_i;
      lamp_mem_read_o     <= memory_read_cycle_flag_i;
      lamp_port_read_o    <= port_read_cycle_flag_i;
      lamp_port_write_o   <= port_write_cycle_flag_i;
      lamp_opcode_fetch_o <= opcode_fetch_flag_i;
      lamp_write_dir_o    <= write_direction_flag_i;
      lamp_stop_ack_o     <= stop_instruction_ack_flag_i;
      lamp_stack_o        <= stack_cycle_flag_i;
      lamp_irq_ack_o      <= irq_ack_flag_i;
    end
  end

  property p_tick_spacing;
    @(posedge clock_i) disable iff (reset_i)
    cpu_tick_o |=> !cpu_tick_o [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("processor ticks closer than the divider allows");

  property p_irq_gate;
    @(posedge clock_i) disable iff (reset_i)
    cpu_irq_o |-> $past(irq_enable_flag_i);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt passed while disabled");

  property p_stopped_no_tick;
    @(posedge clock_i) disable iff (reset_i)
    !running && !$past(running) |-> !cpu_tick_o;
  endproperty
  a_stopped_no_tick: assert property (p_stopped_no_tick)
    else $error("processor ticked while stopped");

  property p_step_cap;
    @(posedge clock_i) disable iff (reset_i)
    mcyc_r == MW'(MAX_MCYCLES) |=> !step_r;
  endproperty
  a_step_cap: assert property (p_step_cap)
    else $error("single step overran the machine cycle cap");

  property p_examine;
    @(posedge clock_i) disable iff (reset_i)
    act[`FPC_ACT_EXAM] && can_act |=> ##1 mem_re_o && mem_addr_o == $past(sw_addr_i, 2);
  endproperty
  a_examine: assert property (p_examine)
    else $error("examine did not read the switch address");

  property p_exnext;
    @(posedge clock_i) disable iff (reset_i)
    act[`FPC_ACT_EXNEXT] && can_act |=> panel_addr_r == $past(panel_addr_r) + 16'h0001;
  endproperty
  a_exnext: assert property (p_exnext)
    else $error("examine next did not advance the address");

  property p_deposit;
    @(posedge clock_i) disable iff (reset_i)
    act[`FPC_ACT_DEP] && can_act && !write_lock && !sw_protect_i |=> ##1
      mem_we_o && mem_wdata_o == $past(sw_addr_i[7:0], 2);
  endproperty
  a_deposit: assert property (p_deposit)
    else $error("deposit did not write the sampled switch byte");

  property p_lock;
    @(posedge clock_i) disable iff (reset_i)
    lamp_write_lock_o |-> !mem_we_o;
  endproperty
  a_lock: assert property (p_lock)
    else $error("memory written while protected");

  property p_pc_clear;
    @(posedge clock_i) disable iff (reset_i)
    act[`FPC_ACT_RESET] && can_act |=> pc_clear_o ##1 !pc_clear_o;
  endproperty
  a_pc_clear: assert property (p_pc_clear)
    else $error("reset actuation did not clear the program counter once");

  property p_wipe;
    @(posedge clock_i) disable iff (reset_i)
    peripheral_wipe_o |-> $past(act[`FPC_ACT_CLEAR]) && !$past(running);
  endproperty
  a_wipe: assert property (p_wipe)
    else $error("peripheral clear without a stopped clear actuation");

  property p_latch;
    @(posedge clock_i) disable iff (reset_i)
    state_r == FPC_LATCH ##1 !running |=> lamp_data_o == $past(mem_rdata_i, 2);
  endproperty
  a_latch: assert property (p_latch)
    else $error("data lamp byte not taken from memory");
endmodule

// ---- fpc_pkg.sv ----
package fpc_pkg;

  typedef enum logic [2:0] {
    FPC_IDLE,
    FPC_WRITE,
    FPC_READ,
    FPC_LATCH
  } fpc_state_type;

endpackage

// ---- front_panel_control_tb_top.sv ----
`timescale 1ns/100ps
`include "fpc_map.svh"
module front_panel_control_tb_top;
  import fpc_pkg::*;
  localparam int DEB  = 4;
  localparam int TICK = 50;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        sw_run_i = 1'b0;
  logic        sw_protect_i = 1'b0;
  logic [6:0]  act = 7'h00;
  logic [15:0] sw_addr_i = 16'h0000;
  logic [15:0] cpu_addr_i = 16'h00FF;
  logic [7:0]  cpu_dout_i = 8'h00;
  logic        cpu_mem_we_i = 1'b0, cpu_mem_re_i = 1'b0, cpu_wait_i = 1'b0;
  logic        cpu_cycle_start_i = 1'b0, cpu_instr_end_i = 1'b0, ext_irq_i = 1'b0;
  logic [9:0]  flags = 10'h000;
  wire         sw_step_i, sw_examine_i, sw_examine_next_i, sw_deposit_i;
  wire         sw_deposit_next_i, sw_reset_i, sw_clear_i;
  wire         irq_enable_flag_i, bus_hold_granted_flag_i, memory_read_cycle_flag_i;
  wire         port_read_cycle_flag_i, port_write_cycle_flag_i, opcode_fetch_flag_i;
  wire         write_direction_flag_i, stop_instruction_ack_flag_i;
  wire         stack_cycle_flag_i, irq_ack_flag_i;
  wire  [7:0]  mem_rdata_i;
  logic [31:0] reg_rdata_o;
  logic [15:0] mem_addr_o, lamp_addr_o;
  logic [7:0]  mem_wdata_o, port_addr_o, lamp_data_o;
  logic        cpu_tick_o, cpu_irq_o, pc_clear_o, peripheral_wipe_o, mem_we_o, mem_re_o;
  logic        port_rd_o, port_wr_o, lamp_irq_enable_o, lamp_write_lock_o, lamp_wait_o;
  logic        lamp_hold_o, lamp_mem_read_o, lamp_port_read_o, lamp_port_write_o;
  logic        lamp_opcode_fetch_o, lamp_write_dir_o, lamp_stop_ack_o, lamp_stack_o;
  logic        lamp_irq_ack_o;
  wire  [9:0]  lamps;
  int          n_errors = 0, checked = 0, cyc = 0, n_tick = 0, n_pc = 0, n_wipe = 0;
  int          end_at = 0, t0 = 0;

  assign {sw_clear_i, sw_reset_i, sw_deposit_next_i, sw_deposit_i,
          sw_examine_next_i, sw_examine_i, sw_step_i} = act;
  assign {irq_enable_flag_i, bus_hold_granted_flag_i, memory_read_cycle_flag_i,
          port_read_cycle_flag_i, port_write_cycle_flag_i, opcode_fetch_flag_i,
          write_direction_flag_i, stop_instruction_ack_flag_i, stack_cycle_flag_i,
          irq_ack_flag_i} = flags;
  assign lamps = {lamp_irq_enable_o, lamp_hold_o, lamp_mem_read_o, lamp_port_read_o,
                  lamp_port_write_o, lamp_opcode_fetch_o, lamp_write_dir_o,
                  lamp_stop_ack_o, lamp_stack_o, lamp_irq_ack_o};

  fpc_panel #(.DEBOUNCE_CYCLES(DEB), .TICK_CYCLES(TICK), .MAX_MCYCLES(5)) uut (.*);

  fpc_mem_model mem_model (
    .clock_i     (clock_i),
    .mem_addr_i  (mem_addr_o),
    .mem_wdata_i (mem_wdata_o),
    .mem_we_i    (mem_we_o),
    .mem_re_i    (mem_re_o),
    .mem_rdata_o (mem_rdata_i)
  );

  always #5 clock_i = ~clock_i;

  // processor stand-in: every tick opens a machine cycle
  always @(posedge clock_i) begin
    cyc++;
    cpu_cycle_start_i <= (cpu_tick_o === 1'b1);
    cpu_instr_end_i <= (cpu_tick_o === 1'b1) && (n_tick + 1 == end_at);
    if (cpu_tick_o === 1'b1) begin
      n_tick++;
    end
    if (pc_clear_o === 1'b1) begin
      n_pc++;
    end
    if (peripheral_wipe_o === 1'b1) begin
      n_wipe++;
    end
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  function automatic logic [7:0] init_val(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // hold past the debounce both ways, then let the sequencer finish
  task automatic press(input int idx);
    @(posedge clock_i);
    act[idx] <= 1'b1;
    repeat (DEB + 4) @(posedge clock_i);
    act[idx] <= 1'b0;
    repeat (DEB + 12) @(posedge clock_i);
    #1;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] d;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (DEB + 4) @(posedge clock_i);
    rd(`FPC_REG_CTRL, d);
    check(d, 32'h0000_0000, "ctrl after reset");
    rd(8'h10, d);
    check(d, 32'h0000_0000, "unmapped read");
    wr(`FPC_REG_STAT, 32'hFFFF_FFFF);
    wr(`FPC_REG_CTRL, 32'h0000_0001);
    rd(`FPC_REG_STAT, d);
    check(d, 32'h0000_0004, "status with soft lock");
    check(32'(lamp_write_lock_o), 32'h1, "lock lamp");
    wr(`FPC_REG_CTRL, 32'h0000_0000);
    $display("test registers done");
    sw_addr_i <= 16'h0080;
    press(`FPC_ACT_EXAM);
    check(32'(lamp_addr_o), 32'h0080, "examine address");
    check(32'(lamp_data_o), 32'(init_val(8'h80)), "examine data");
    sw_addr_i <= 16'h003A;
    press(`FPC_ACT_DEP);
    check(32'(mem_model.mem[8'h80]), 32'h3A, "deposit byte");
    check(32'(lamp_data_o), 32'h3A, "deposit lamp");
    sw_addr_i <= 16'h00C5;
    press(`FPC_ACT_DEPNEXT);
    check(32'(mem_model.mem[8'h81]), 32'hC5, "deposit next byte");
    check(32'(lamp_addr_o), 32'h0081, "deposit next address");
    check(32'(mem_model.mem[8'h80]), 32'h3A, "earlier deposit kept");
    press(`FPC_ACT_EXNEXT);
    check(32'(lamp_addr_o), 32'h0082, "examine next address");
    check(32'(lamp_data_o), 32'(init_val(8'h82)), "examine next data");
    sw_protect_i <= 1'b1;
    sw_addr_i <= 16'h00FF;
    press(`FPC_ACT_DEP);
    check(32'(mem_model.mem[8'h82]), 32'(init_val(8'h82)), "protected byte");
    check(32'(lamp_write_lock_o), 32'h1, "protect lamp");
    sw_protect_i <= 1'b0;
    rd(`FPC_REG_ADDR, d);
    check(d, 32'h0000_0082, "panel address");
    $display("test memory done");
    t0 = n_pc;
    press(`FPC_ACT_RESET);
    check(n_pc - t0, 1, "program counter clear pulses");
    t0 = n_wipe;
    press(`FPC_ACT_CLEAR);
    check(n_wipe - t0, 1, "peripheral clear pulses");
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      flags <= 10'h001 << i;
      repeat (3) @(posedge clock_i);
      #1 check(32'(lamps), 32'(10'h001 << i), "status lamp");
    end
    check(32'(lamp_wait_o), 32'h1, "wait lamp while stopped");
    ext_irq_i <= 1'b1;
    flags <= 10'h000;
    repeat (3) @(posedge clock_i);
    #1 check(32'(cpu_irq_o), 32'h0, "masked interrupt");
    flags <= 10'h200;
    repeat (3) @(posedge clock_i);
    #1 check(32'(cpu_irq_o), 32'h1, "enabled interrupt");
    flags <= 10'h000;
    ext_irq_i <= 1'b0;
    $display("test lamps done");
    for (int k = 0; k < 2; k++) begin
      t0 = n_tick;
      end_at = (k == 0) ? t0 + 3 : 0;
      press(`FPC_ACT_STEP);
      repeat (8 * TICK) @(posedge clock_i);
      #1 check(n_tick - t0, (k == 0) ? 3 : 5, "ticks in one step");
    end
    $display("test step done");
    sw_run_i <= 1'b1;
    flags <= 10'h060;
    repeat (TICK + 10) @(posedge clock_i);
    #1 t0 = n_tick;
    repeat (10 * TICK) @(posedge clock_i);
    #1 check(n_tick - t0, 10, "ticks while running");
    check(32'(port_addr_o), 32'h00FF, "port address");
    check(32'(port_rd_o), 32'h1, "port read");
    check(32'(port_wr_o), 32'h1, "port write");
    check(32'(lamp_addr_o), 32'h00FF, "address lamps follow the bus");
    check(32'(lamp_wait_o), 32'h0, "wait lamp while running");
    cpu_wait_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1 check(32'(lamp_wait_o), 32'h1, "wait lamp in wait state");
    cpu_wait_i <= 1'b0;
    sw_addr_i <= 16'h0010;
    press(`FPC_ACT_EXAM);
    rd(`FPC_REG_ADDR, d);
    check(d, 32'h0000_0082, "examine while running ignored");
    wr(`FPC_REG_CTRL, 32'h0000_0002);
    repeat (TICK + 10) @(posedge clock_i);
    #1 t0 = n_tick;
    repeat (4 * TICK) @(posedge clock_i);
    #1 check(n_tick - t0, 0, "ticks while halted");
    wr(`FPC_REG_CTRL, 32'h0000_0000);
    sw_run_i <= 1'b0;
    flags <= 10'h000;
    $display("test run done");
    wrap_up();
  end
endmodule
